/* hw/siq_pkg.sv */
package siq_pkg;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_SKEW = 8'h04;
   localparam logic [7:0] REG_RATE = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0C;
   localparam logic [7:0] REG_TXS = 8'h10;
   localparam logic [7:0] REG_RXS = 8'h14;
   // control fields
   localparam int CTRL_EMBED = 0;
   localparam int CTRL_STDCM = 1;
   localparam int CTRL_CML = 2;
   localparam int CTRL_DRIVE = 4;
   localparam int CTRL_BAND = 6;
   localparam logic [1:0] CML_RST = 2'h1;
   localparam logic [1:0] DRIVE_RST = 2'h1;
   localparam logic [1:0] CML_IGNORED = 2'h0;
   localparam logic [2:0] SKEW_RST = 3'h0;
   // rate fields: divider of the word rate, 1 to 10
   localparam int RATE_TX = 0;
   localparam int RATE_RX = 8;
   localparam logic [3:0] RATE_MIN = 4'h1;
   localparam logic [3:0] RATE_MAX = 4'hA;
   // status fields
   localparam int ST_SYNC = 0;
   localparam int ST_FAIL = 1;
   localparam int ST_FSAFE = 2;
   localparam int ST_TXCTL = 3;
   localparam int ST_PEND = 4;
   // sample fields in the sample registers
   localparam int SAMP_I = 16;
   localparam int SAMP_Q = 0;
   localparam int SAMP_W = 13;
   localparam int FIELD_W = 14;
   // word layout
   localparam logic [1:0] I_SYNC = 2'h2;
   localparam logic [1:0] Q_SYNC = 2'h1;
   localparam logic [4:0] WORD_LAST = 5'h1F;
   localparam logic [5:0] ZERO_RUN = 6'h20;
   // link timing
   localparam int LINK_FREQ_KHZ = 64000;
   localparam int HCLK_FREQ_KHZ = 10000;
   localparam int HALF_CALC = HCLK_FREQ_KHZ / (2 * LINK_FREQ_KHZ);
   localparam int LINK_HALF_CYC = (HALF_CALC < 2) ? 2 : HALF_CALC;
   typedef enum logic [2:0] {
      DS_HUNT = 3'b001,
      DS_WORD = 3'b010,
      DS_GAP = 3'b100
   } siq_dstate_t;
endpackage : siq_pkg

/* hw/siq_word_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface siq_word_if;
   logic word_stb;
   logic fail_stb;
   logic [13:0] i_field;
   logic [13:0] q_field;
   modport rcv (output word_stb, output fail_stb, output i_field,
      output q_field);
   modport core (input word_stb, input fail_stb, input i_field,
      input q_field);
endinterface : siq_word_if
`default_nettype wire

/* hw/siq_tx_deser.sv */
`timescale 1ns/1ns
`default_nettype none
module siq_tx_deser
   import siq_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic tx_link_clock,
   input wire logic tx_serial_data,
   siq_word_if.rcv w
);
   logic [2:0] ck_sync_r;
   logic [2:0] dt_sync_r;
   logic ck_lvl_r;
   logic ck_edge;
   logic bit_stb_r;
   logic rise_r;
   logic bit_v;
   siq_dstate_t st_r;
   logic [30:0] sh_r;
   logic [4:0] nbit_r;
   logic [5:0] zcnt_r;
   logic [31:0] wrd;
   logic wstb_r;
   logic fstb_r;
   logic [13:0] ifl_r;
   logic [13:0] qfl_r;

   // an edge counts once the second and third stages agree
   assign ck_edge = (ck_sync_r[1] == ck_sync_r[2]) &&
      (ck_sync_r[2] != ck_lvl_r);
   assign bit_v = dt_sync_r[2];
   assign wrd = {sh_r, bit_v};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ck_sync_r <= 3'h0;
         dt_sync_r <= 3'h0;
         ck_lvl_r <= 1'b0;
         bit_stb_r <= 1'b0;
         rise_r <= 1'b0;
      end else begin
         ck_sync_r <= {ck_sync_r[1:0], tx_link_clock};
         dt_sync_r <= {dt_sync_r[1:0], tx_serial_data};
         if (ck_edge) ck_lvl_r <= ck_sync_r[2];
         // data is edge aligned, so it is taken one cycle after the edge
         bit_stb_r <= ck_edge;
         rise_r <= ck_edge & ck_sync_r[2];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= DS_HUNT;
         sh_r <= 31'h0;
         nbit_r <= 5'h0;
         zcnt_r <= 6'h0;
         wstb_r <= 1'b0;
         fstb_r <= 1'b0;
         ifl_r <= 14'h0;
         qfl_r <= 14'h0;
      end else begin
         wstb_r <= 1'b0;
         fstb_r <= 1'b0;
         if (bit_stb_r) begin
            case (st_r)
               DS_HUNT: begin
                  if (!bit_v) begin
                     if (zcnt_r != ZERO_RUN) zcnt_r <= zcnt_r + 6'h1;
                  end else begin
                     zcnt_r <= 6'h0;
                     if (zcnt_r == ZERO_RUN && rise_r) begin
                        st_r <= DS_WORD;
                        sh_r <= 31'h1;
                        nbit_r <= 5'h1;
                     end
                  end
               end
               DS_WORD: begin
                  sh_r <= {sh_r[29:0], bit_v};
                  nbit_r <= nbit_r + 5'h1;
                  if (nbit_r == WORD_LAST) begin
                     zcnt_r <= 6'h0;
                     if (wrd[31:30] == I_SYNC && wrd[15:14] == Q_SYNC) begin
                        wstb_r <= 1'b1;
                        ifl_r <= wrd[29:16];
                        qfl_r <= wrd[13:0];
                        st_r <= DS_GAP;
                     end else begin
                        fstb_r <= 1'b1;
                        st_r <= DS_HUNT;
                     end
                  end
               end
               DS_GAP: begin
                  if (!bit_v) begin
                     if (zcnt_r != ZERO_RUN) zcnt_r <= zcnt_r + 6'h1;
                  end else if (zcnt_r == 6'h0 || zcnt_r == ZERO_RUN) begin
                     // back to back or after a full zero word
                     st_r <= DS_WORD;
                     sh_r <= 31'h1;
                     nbit_r <= 5'h1;
                     zcnt_r <= 6'h0;
                  end else begin
                     fstb_r <= 1'b1;
                     st_r <= DS_HUNT;
                     zcnt_r <= 6'h0;
                  end
               end
               default: st_r <= DS_HUNT;
            endcase
         end
      end
   end

   assign w.word_stb = wstb_r;
   assign w.fail_stb = fstb_r;
   assign w.i_field = ifl_r;
   assign w.q_field = qfl_r;

   hunt_zero_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_r == DS_HUNT ##1 st_r == DS_WORD) |-> $past(zcnt_r) == ZERO_RUN)
      else $error("word started without a full zero run");
endmodule : siq_tx_deser
`default_nettype wire

/* hw/siq_link_core.sv */
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module siq_link_core
   import siq_pkg::*;
#(
   parameter int HALF_CYC = LINK_HALF_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic rx_link_clock,
   output logic rx_serial_data_subghz,
   output logic rx_serial_data_2g4,
   input wire logic tx_link_clock,
   input wire logic tx_serial_data,
   input wire logic tx_fail_safe_detect,
   output logic standard_common_mode_select,
   output logic [1:0] common_mode_level,
   output logic [1:0] link_drive_current,
   output logic [2:0] output_skew_setting,
   output logic [3:0] tx_frontend_rate_config,
   output logic [3:0] rx_frontend_rate_config,
   output logic tx_embedded_control
);
   localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
   localparam logic [7:0] HALF_MID = 8'(HALF_CYC / 2 - 1);

   siq_word_if wif ();

   logic ap;
   logic hit;
   logic wr_r;
   logic [7:0] wa_r;
   logic [31:0] rdata_nxt;
   logic [31:0] rdata_r;
   logic rd_stat;
   logic [6:0] ctrl_r;
   logic [2:0] skew_r;
   logic [3:0] txrate_r;
   logic [3:0] rxrate_r;
   logic sync_r;
   logic sfail_r;
   logic txc_r;
   logic pend_r;
   logic [12:0] rxi_r;
   logic [12:0] rxq_r;
   logic [12:0] txi_r;
   logic [12:0] txq_r;
   logic [2:0] fs_sync_r;
   logic fsafe_r;
   logic [1:0] cml_r;
   logic stdcm_r;
   logic [7:0] div_r;
   logic lclk_r;
   logic tick_mid;
   logic tick_tgl;
   logic load;
   logic load_data;
   logic [31:0] ser_r;
   logic [4:0] bitn_r;
   logic [3:0] slot_r;
   logic [31:0] word_nxt;
   logic nbit;
   logic sub_r;
   logic g24_r;

   function automatic logic [3:0] siq_clamp(input logic [3:0] v);
      logic [3:0] r;
      r = v;
      if (v < RATE_MIN) r = RATE_MIN;
      if (v > RATE_MAX) r = RATE_MAX;
      return r;
   endfunction : siq_clamp

   // bus slave: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_r;
   assign ap = hsel && htrans[1] && hready;
   assign hit = (haddr[31:8] == 24'h0);
   assign rd_stat = ap && !hwrite && hit && haddr[7:0] == REG_STAT;

   always_comb begin
      rdata_nxt = 32'h0;
      if (hit) begin
         case (haddr[7:0])
            REG_CTRL: rdata_nxt[6:0] = ctrl_r;
            REG_SKEW: rdata_nxt[2:0] = skew_r;
            REG_RATE: begin
               rdata_nxt[RATE_TX +: 4] = txrate_r;
               rdata_nxt[RATE_RX +: 4] = rxrate_r;
            end
            REG_STAT: begin
               rdata_nxt[ST_SYNC] = sync_r;
               rdata_nxt[ST_FAIL] = sfail_r;
               rdata_nxt[ST_FSAFE] = fsafe_r;
               rdata_nxt[ST_TXCTL] = txc_r;
               rdata_nxt[ST_PEND] = pend_r;
            end
            REG_TXS: begin
               rdata_nxt[SAMP_I +: SAMP_W] = txi_r;
               rdata_nxt[SAMP_Q +: SAMP_W] = txq_r;
            end
            REG_RXS: begin
               rdata_nxt[SAMP_I +: SAMP_W] = rxi_r;
               rdata_nxt[SAMP_Q +: SAMP_W] = rxq_r;
            end
            default: rdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_r <= 1'b0;
         wa_r <= 8'h0;
         rdata_r <= 32'h0;
      end else begin
         wr_r <= ap && hwrite && hit;
         if (ap) wa_r <= haddr[7:0];
         if (ap && !hwrite) rdata_r <= rdata_nxt;
      end
   end

   // configuration registers, written in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= {1'b0, DRIVE_RST, CML_RST, 2'h0};
         skew_r <= SKEW_RST;
         txrate_r <= RATE_MIN;
         rxrate_r <= RATE_MIN;
      end else if (wr_r) begin
         case (wa_r)
            REG_CTRL: ctrl_r <= hwdata[6:0];
            REG_SKEW: skew_r <= hwdata[2:0];
            REG_RATE: begin
               txrate_r <= siq_clamp(hwdata[RATE_TX +: 4]);
               rxrate_r <= siq_clamp(hwdata[RATE_RX +: 4]);
            end
            default: ;
         endcase
      end
   end

   // analog settings leave through flops; std select masks the fine level
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stdcm_r <= 1'b0;
         cml_r <= CML_RST;
      end else begin
         stdcm_r <= ctrl_r[CTRL_STDCM];
         cml_r <= ctrl_r[CTRL_STDCM] ? CML_IGNORED :
            ctrl_r[CTRL_CML +: 2];
      end
   end
   assign standard_common_mode_select = stdcm_r;
   assign common_mode_level = cml_r;
   assign link_drive_current = ctrl_r[CTRL_DRIVE +: 2];
   assign output_skew_setting = skew_r;
   assign tx_frontend_rate_config = txrate_r;
   assign rx_frontend_rate_config = rxrate_r;

   // fail-safe comparator output comes from the pad domain
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fs_sync_r <= 3'h0;
         fsafe_r <= 1'b0;
      end else begin
         fs_sync_r <= {fs_sync_r[1:0], tx_fail_safe_detect};
         if (fs_sync_r[1] == fs_sync_r[2]) begin
            fsafe_r <= fs_sync_r[2];
         end
      end
   end

   siq_tx_deser u_deser (
      .hclk(hclk),
      .hresetn(hresetn),
      .tx_link_clock(tx_link_clock),
      .tx_serial_data(tx_serial_data),
      .w(wif.rcv)
   );

   // incoming word status; a new word wins over the read clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_r <= 1'b0;
         sfail_r <= 1'b0;
         txc_r <= 1'b0;
         txi_r <= 13'h0;
         txq_r <= 13'h0;
      end else begin
         if (wif.word_stb) begin
            sync_r <= 1'b1;
            sfail_r <= 1'b0;
            txi_r <= wif.i_field[FIELD_W-1:1];
            txq_r <= wif.q_field[FIELD_W-1:1];
            if (ctrl_r[CTRL_EMBED]) begin
               txc_r <= wif.i_field[0];
            end
         end else if (wif.fail_stb) begin
            sync_r <= 1'b0;
            sfail_r <= 1'b1;
         end else if (rd_stat) begin
            sync_r <= 1'b0;
         end
         if (!ctrl_r[CTRL_EMBED]) txc_r <= 1'b0;
      end
   end
   assign tx_embedded_control = txc_r;

   // link clock made by dividing hclk; it never stops
   assign tick_tgl = (div_r == HALF_LAST);
   assign tick_mid = (div_r == HALF_MID);
   assign load = tick_mid && (bitn_r == WORD_LAST);
   assign load_data = load && (slot_r == 4'h0) && pend_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_r <= 8'h0;
         lclk_r <= 1'b0;
      end else begin
         div_r <= tick_tgl ? 8'h0 : div_r + 8'h1;
         if (tick_tgl) lclk_r <= ~lclk_r;
      end
   end
   assign rx_link_clock = lclk_r;

   always_comb begin
      word_nxt = 32'h0;
      if (load_data) begin
         word_nxt = {I_SYNC, rxi_r, 1'b0, Q_SYNC, rxq_r, 1'b0};
      end
   end

   // bits change half way between clock edges so they sit centred
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ser_r <= 32'h0;
         bitn_r <= WORD_LAST;
         slot_r <= 4'h0;
      end else if (tick_mid) begin
         if (load) begin
            ser_r <= word_nxt;
            bitn_r <= 5'h0;
            slot_r <= (slot_r >= rxrate_r - 4'h1) ? 4'h0 :
               slot_r + 4'h1;
         end else begin
            ser_r <= {ser_r[30:0], 1'b0};
            bitn_r <= bitn_r + 5'h1;
         end
      end
   end

   assign nbit = load ? word_nxt[31] : ser_r[30];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sub_r <= 1'b0;
         g24_r <= 1'b0;
      end else if (tick_mid) begin
         sub_r <= nbit & ~ctrl_r[CTRL_BAND];
         g24_r <= nbit & ctrl_r[CTRL_BAND];
      end
   end
   assign rx_serial_data_subghz = sub_r;
   assign rx_serial_data_2g4 = g24_r;

   // sample mailbox; a fresh write wins over the load that empties it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_r <= 1'b0;
         rxi_r <= 13'h0;
         rxq_r <= 13'h0;
      end else begin
         if (wr_r && wa_r == REG_RXS) begin
            pend_r <= 1'b1;
            rxi_r <= hwdata[SAMP_I +: SAMP_W];
            rxq_r <= hwdata[SAMP_Q +: SAMP_W];
         end else if (load_data) begin
            pend_r <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence data_load_s;
      (load_data && !wr_r) ##1 !tick_mid;
   endsequence

   sync_pattern_a: assert property (
      load_data |=> ser_r[31:30] == I_SYNC && ser_r[15:14] == Q_SYNC)
      else $error("outgoing word lacks sync patterns");
   unused_lsb_a: assert property (
      load_data |=> ser_r[16] == 1'b0 && ser_r[0] == 1'b0)
      else $error("outgoing bit 0 of a field is not zero");
   zero_fill_a: assert property (
      (load && !load_data) |=> ser_r == 32'h0)
      else $error("idle slot word not all zero");
   clock_half_a: assert property (
      $changed(lclk_r) |-> $past(div_r) == HALF_LAST)
      else $error("link clock half period wrong");
   data_centred_a: assert property (
      $changed(sub_r) |-> !$changed(lclk_r) && $past(div_r) == HALF_MID)
      else $error("outgoing data moved at a clock edge");
   first_rising_a: assert property (
      load |-> !lclk_r)
      else $error("word did not start in the low phase");
   slot_gap_a: assert property (
      load |-> slot_r < RATE_MAX && (!load_data || slot_r == 4'h0))
      else $error("data word outside its slot");
   pend_clear_a: assert property (
      data_load_s |-> !pend_r)
      else $error("sample sent but still pending");
   cm_override_a: assert property (
      ctrl_r[CTRL_STDCM] |=> stdcm_r && cml_r == CML_IGNORED)
      else $error("fine common mode not ignored");
   embed_ignore_a: assert property (
      !ctrl_r[CTRL_EMBED] |=> !txc_r)
      else $error("embedded control taken while disabled");
   sync_set_a: assert property (
      wif.word_stb |=> sync_r && !sfail_r)
      else $error("good word did not set sync");
endmodule : siq_link_core
`default_nettype wire

/* dv/siq_bb_model.sv */
`timescale 1ns/1ns
`default_nettype none
module siq_bb_model (
   output logic tx_link_clock,
   output logic tx_serial_data
);
   // clock stands low between frames; the open data line rests at the
   // pull-up level, so nothing stale looks like a zero
   initial begin
      tx_link_clock = 1'b0;
      tx_serial_data = 1'b1;
   end
   // one bit per clock edge, launched on the edge itself
   task automatic put_bit(input logic b);
      tx_link_clock = ~tx_link_clock;
      tx_serial_data = b;
      #400;
   endtask : put_bit
   // zero preamble, word, one zero word, word; bit 31 on a rising edge
   task automatic send_frame(input logic [31:0] w0, input logic [31:0] w1);
      for (int i = 0; i < 32; i++) put_bit(1'b0);
      for (int i = 31; i >= 0; i--) put_bit(w0[i]);
      for (int i = 0; i < 32; i++) put_bit(1'b0);
      for (int i = 31; i >= 0; i--) put_bit(w1[i]);
      tx_serial_data = 1'b1;
   endtask : send_frame
endmodule : siq_bb_model
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
$display("BAD %0t got %h want %h", $time, (a), (e)); end end
module tb_top
   import siq_pkg::*;
();
   localparam int HC = 4;
   int errors = 0;
   int total_checks = 0;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, common_mode_level, link_drive_current;
   logic [2:0] hsize, output_skew_setting;
   logic [3:0] tx_frontend_rate_config, rx_frontend_rate_config;
   logic rx_link_clock, rx_serial_data_subghz, rx_serial_data_2g4;
   logic tx_link_clock, tx_serial_data, tx_fail_safe_detect;
   logic standard_common_mode_select, tx_embedded_control;
   siq_link_core #(.HALF_CYC(HC)) u_dut (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
      .hresp, .hrdata, .rx_link_clock, .rx_serial_data_subghz,
      .rx_serial_data_2g4, .tx_link_clock, .tx_serial_data,
      .tx_fail_safe_detect, .standard_common_mode_select,
      .common_mode_level, .link_drive_current, .output_skew_setting,
      .tx_frontend_rate_config, .rx_frontend_rate_config,
      .tx_embedded_control);
   siq_bb_model u_bb (.tx_link_clock, .tx_serial_data);
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   task automatic final_report;
      if (errors == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
   initial begin
      repeat (40000) @(posedge hclk);
      errors++;
      final_report();
   end
   function automatic logic [31:0] mk_word(logic [12:0] a, logic [12:0] b,
      logic c);
      return {2'b10, a, c, 2'b01, b, 1'b0};
   endfunction : mk_word
   function automatic logic [3:0] clamp(logic [3:0] v);
      return (v < RATE_MIN) ? RATE_MIN : (v > RATE_MAX) ? RATE_MAX : v;
   endfunction : clamp
   // single transfer; held until hready is seen high at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr
   // outgoing stream decoder: samples at each link clock edge
   logic rck_q = 1'b0;
   logic seen = 1'b0;
   logic band = 1'b0;
   int since = 0;
   int nb = 0;
   int zr = 0;
   logic [31:0] sh;
   logic [31:0] rx_q[$];
   int gap_q[$];
   task automatic wait_rx(input int n);
      int t = 0;
      while (rx_q.size() < n && t < 4000) begin
         @(posedge hclk);
         t++;
      end
   endtask : wait_rx
   always @(posedge hclk) begin
      logic d;
      d = band ? rx_serial_data_2g4 : rx_serial_data_subghz;
      since++;
      if (hresetn && rx_link_clock !== rck_q) begin
         if (seen) `CHK(since, HC)
         seen = 1'b1;
         since = 0;
         `CHK(band ? rx_serial_data_subghz : rx_serial_data_2g4, 1'b0)
         if (nb > 0) begin
            sh = {sh[30:0], d};
            nb--;
            if (nb == 0) rx_q.push_back(sh);
         end else if (d === 1'b1) begin
            `CHK(rx_link_clock, 1'b1)
            sh = 32'h1;
            nb = 31;
            gap_q.push_back(zr);
            zr = 0;
         end else zr++;
      end
      rck_q = rx_link_clock;
   end
   initial begin
      logic [31:0] r, w0, w1;
      logic [12:0] i, q;
      logic [3:0] dv, e;
      logic [6:0] c;
      void'($urandom(32'hD0B5F37B));
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      tx_fail_safe_detect = 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      `CHK(common_mode_level, CML_RST)
      `CHK(tx_frontend_rate_config, RATE_MIN)
      bus(1'b0, REG_CTRL, 32'h0, r);
      `CHK(r, 32'h14)
      bus(1'b0, 8'h1C, 32'h0, r);
      `CHK(r, 32'h0)
      tx_fail_safe_detect <= 1'b1;
      repeat (4) @(posedge hclk);
      bus(1'b0, REG_STAT, 32'h0, r);
      `CHK(r[ST_FSAFE], 1'b1)
      tx_fail_safe_detect <= 1'b0;
      for (int n = 0; n < 6; n++) begin
         c = 7'($urandom);
         c[1] = n[0];
         c[6] = 1'b0;
         wr(REG_CTRL, {25'h0, c});
         bus(1'b0, REG_CTRL, 32'h0, r);
         `CHK(r[6:0], c)
         `CHK(standard_common_mode_select, c[1])
         `CHK(common_mode_level, c[1] ? CML_IGNORED : c[3:2])
         `CHK(link_drive_current, c[5:4])
      end
      for (int n = 0; n < 4; n++) begin
         dv = (n == 0) ? 4'h0 : (n == 1) ? 4'hF : 4'($urandom_range(10, 1));
         e = clamp(dv);
         wr(REG_RATE, {20'h0, dv, 4'h0, dv});
         bus(1'b0, REG_RATE, 32'h0, r);
         `CHK(r, {20'h0, e, 4'h0, e})
         `CHK(tx_frontend_rate_config, e)
      end
      // skew is only touched while the link carries nothing
      wr(REG_SKEW, {29'h0, 3'h5});
      bus(1'b0, REG_SKEW, 32'h0, r);
      `CHK(output_skew_setting, 3'h5)
      for (int b = 0; b < 2; b++) begin
         dv = 4'($urandom_range(10, 2));
         band = b[0];
         wr(REG_CTRL, {25'h0, b[0], 6'h14});
         wr(REG_RATE, {20'h0, dv, 8'h01});
         rx_q.delete();
         gap_q.delete();
         i = 13'($urandom);
         q = 13'($urandom);
         // extremes of the signed range on the second pin
         if (b == 1) i = 13'h1000;
         if (b == 1) q = 13'h0FFF;
         wr(REG_RXS, {3'h0, i, 3'h0, q});
         `CHK(rx_frontend_rate_config, dv)
         wait_rx(1);
         wr(REG_RXS, {3'h0, ~i, 3'h0, ~q});
         wait_rx(2);
         `CHK(rx_q[0], mk_word(i, q, 1'b0))
         `CHK(rx_q[1], mk_word(~i, ~q, 1'b0))
         `CHK(gap_q[1], (int'(dv) - 1) * 32)
      end
      band = 1'b0;
      wr(REG_RATE, 32'h202);
      // bad sync first, then a good frame must clear the failure
      for (int n = 0; n < 3; n++) begin
         wr(REG_CTRL, {31'h0A, n == 1});
         i = 13'($urandom);
         q = 13'($urandom);
         w0 = mk_word(q, i, 1'b0);
         w1 = mk_word(i, q, 1'b1);
         if (n == 0) w1[15:14] = 2'h3;
         #37;
         u_bb.send_frame(w0, w1);
         repeat (10) @(posedge hclk);
         bus(1'b0, REG_STAT, 32'h0, r);
         `CHK(r[ST_FAIL], n == 0)
         `CHK(r[ST_TXCTL], n == 1)
         `CHK(tx_embedded_control, n == 1)
         if (n > 0) begin
            `CHK(r[ST_SYNC], 1'b1)
            bus(1'b0, REG_STAT, 32'h0, r);
            `CHK(r[ST_SYNC], 1'b0)
            bus(1'b0, REG_TXS, 32'h0, r);
            `CHK(r, {3'h0, i, 3'h0, q})
         end
      end
      final_report();
   end
endmodule : tb_top
`default_nettype wire
